// ==== logic/isp_pkg.sv ====
/*
 * shared constants, types and fixed correction tables of the inertial
 * sample processing chain.
 * assumes a 50 MHz system clock and 16-bit signed converter samples.
 */
package isp_pkg;

    // data shape
    localparam int DW         = 16;
    localparam int CH         = 6;
    localparam int AX         = 3;
    localparam int FRAC       = 14;
    localparam int WIDE_W     = 40;
    typedef logic [DW-1:0]          isp_word_t;
    typedef isp_word_t [AX-1:0]     isp_vec3_t;
    typedef isp_word_t [CH-1:0]     isp_vec_t;

    // timing
    localparam int unsigned CLK_HZ        = 50_000_000;
    localparam int unsigned GYRO_CONV_HZ  = 4100;
    localparam int unsigned PROC_HZ       = 2000;
    localparam int unsigned GYRO_HALF_CYC = CLK_HZ / (2 * GYRO_CONV_HZ);
    localparam int unsigned PROC_CYC      = CLK_HZ / PROC_HZ;
    localparam int GCNT_W = 14;
    localparam int PCNT_W = 15;
    localparam int PER_W  = 26;
    localparam int ACC_W  = 27;

    // control fields
    localparam int MISC_DRPOL_BIT = 0;
    localparam int MISC_CLK_LSB   = 2;
    localparam int MISC_CLK_W     = 3;
    localparam int MISC_POP_BIT   = 6;
    localparam int MISC_LING_BIT  = 7;
    localparam logic [MISC_CLK_W-1:0] CLK_INTERNAL = 3'h0;
    localparam logic [MISC_CLK_W-1:0] CLK_DIRECT   = 3'h1;
    localparam logic [MISC_CLK_W-1:0] CLK_SCALED   = 3'h2;
    localparam logic [MISC_CLK_W-1:0] CLK_PULSE    = 3'h5;
    localparam isp_word_t MISC_DEF  = 16'h00C1;
    localparam isp_word_t FILT_DEF  = 16'h0000;
    localparam isp_word_t DEC_DEF   = 16'h0000;
    localparam isp_word_t SCALE_DEF = 16'h07D0;
    localparam int FILT_LOG_W = 2;
    localparam logic [FILT_LOG_W-1:0] FILT_LOG_MAX = 2'h3;
    localparam int AVG_DEPTH  = 8;
    localparam int AVG_SUM_W  = 19;
    localparam int DEC_W      = 11;
    localparam int SUM_W      = 32;
    localparam int DIAG_SAT_BIT = 0;

    // byte addresses, low byte even, high byte odd
    localparam int ADDR_W = 7;
    localparam logic [ADDR_W-1:0] A_DIAG  = 7'h02;
    localparam logic [ADDR_W-1:0] A_OUT0  = 7'h04;
    localparam logic [ADDR_W-1:0] A_CNT   = 7'h10;
    localparam logic [ADDR_W-1:0] A_ID    = 7'h12;
    localparam logic [ADDR_W-1:0] A_FILT  = 7'h5C;
    localparam logic [ADDR_W-1:0] A_MISC  = 7'h60;
    localparam logic [ADDR_W-1:0] A_SCALE = 7'h62;
    localparam logic [ADDR_W-1:0] A_DEC   = 7'h64;

    // fixed correction tables, Q2.14, row major
    localparam logic [8:0][DW-1:0] GYRO_M = {16'h4000, 16'h0000, 16'h0000,
                                             16'h0000, 16'h4000, 16'h0000,
                                             16'h0000, 16'h0000, 16'h4000};
    localparam logic [8:0][DW-1:0] GYRO_L = '0;
    localparam logic [2:0][DW-1:0] GYRO_B = '0;
    localparam logic [8:0][DW-1:0] ACCL_M = {16'h4000, 16'h0000, 16'h0000,
                                             16'h0000, 16'h4000, 16'h0000,
                                             16'h0000, 16'h0000, 16'h4000};
    localparam logic [2:0][DW-1:0] ACCL_B = '0;
    localparam logic [5:0][DW-1:0] ACCL_P = '0;

endpackage

// ==== logic/isp_stage_if.sv ====
/*
 * sample stream between the stages of the chain.
 * assumes one producer and one consumer on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface isp_stage_if;
    import isp_pkg::*;
    logic     valid;
    isp_vec_t data;
    modport src (output valid, output data);
    modport snk (input valid, input data);
endinterface
`default_nettype wire

// ==== logic/isp_avg_stage.sv ====
/*
 * one moving average stage over 1, 2, 4 or 8 samples on all channels.
 * assumes the selected length changes only between samples.
 */
`timescale 1ns/100ps
`default_nettype none
module isp_avg_stage (
    // clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    // configuration
    input  wire logic [isp_pkg::FILT_LOG_W-1:0] len_log_i,
    // stream
    isp_stage_if.snk                           in_if,
    isp_stage_if.src                           out_if
);
    import isp_pkg::*;

    typedef struct packed {
        isp_vec_t [AVG_DEPTH-1:0] hist;
        logic                     valid;
        isp_vec_t                 data;
    } isp_avg_st_t;

    isp_avg_st_t st_q;
    isp_avg_st_t st_d;

    assign out_if.valid = st_q.valid;
    assign out_if.data  = st_q.data;

    // shift in a sample and average the newest 2^len entries
    always_comb begin
        logic signed [AVG_SUM_W-1:0] sum;
        sum = '0;
        st_d = st_q;
        st_d.valid = 1'b0;
        if (in_if.valid) begin
            st_d.hist = {st_q.hist[AVG_DEPTH-2:0], in_if.data};
            for (int c = 0; c < CH; c++) begin
                sum = '0;
                for (int k = 0; k < AVG_DEPTH; k++) begin
                    if (k < (1 << len_log_i)) begin
                        sum = sum + AVG_SUM_W'($signed(st_d.hist[k][c]));
                    end
                end
                st_d.data[c] = DW'(sum >>> len_log_i);
            end
            st_d.valid = 1'b1;
        end
    end

    // state register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule
`default_nettype wire

// ==== logic/isp_decim.sv ====
/*
 * averaging decimator: sums n+1 samples and emits their mean once.
 * assumes n changes only while no block is in progress, or accepts one odd block.
 */
`timescale 1ns/100ps
`default_nettype none
module isp_decim (
    // clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    // configuration, samples per output minus one
    input  wire logic [isp_pkg::DEC_W-1:0] dec_n_i,
    // stream
    isp_stage_if.snk                      in_if,
    isp_stage_if.src                      out_if
);
    import isp_pkg::*;

    typedef struct packed {
        logic [DEC_W-1:0]           cnt;
        logic [CH-1:0][SUM_W-1:0]   sum;
        logic                       valid;
        isp_vec_t                   data;
    } isp_dec_st_t;

    isp_dec_st_t st_q;
    isp_dec_st_t st_d;

    assign out_if.valid = st_q.valid;
    assign out_if.data  = st_q.data;

    // accumulate, divide by the block length at the last sample
    always_comb begin
        logic signed [SUM_W-1:0] acc;
        logic signed [SUM_W-1:0] n_div;
        acc = '0;
        n_div = $signed(SUM_W'(dec_n_i) + SUM_W'(1));
        st_d = st_q;
        st_d.valid = 1'b0;
        if (in_if.valid) begin
            for (int c = 0; c < CH; c++) begin
                acc = $signed(st_q.sum[c]) + SUM_W'($signed(in_if.data[c]));
                if (st_q.cnt >= dec_n_i) begin
                    st_d.data[c] = DW'(acc / n_div);
                    st_d.sum[c]  = '0;
                end else begin
                    st_d.sum[c]  = acc;
                end
            end
            if (st_q.cnt >= dec_n_i) begin
                st_d.cnt   = '0;
                st_d.valid = 1'b1;
            end else begin
                st_d.cnt = st_q.cnt + DEC_W'(1);
            end
        end
    end

    // state register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule
`default_nettype wire

// ==== logic/isp_chain_top.sv ====
/*
 * inertial sample processing chain: converter clocking, processing rate,
 * fixed correction, two stage bartlett fir, decimation and byte wide
 * output and control registers.
 * assumes converter samples and sync input are synchronous to clk_i, and
 * the host writes the low byte of a register before its high byte.
 */
// Function
// - runs continuously at 2000 SPS from defaults
// - gyro converter clocks at 4100 Hz
// - internal mode processing tick fixed at 2000 Hz
// - internal clock mode is the default
// - three external sync modes set processing rate
// - gyro equals scale matrix, bias, linear-g
// - misc bit 7 switches linear-g term
// - accel equals scale matrix, bias, percussion terms
// - misc bit 6 switches percussion term
// - correction tables fixed, never host visible
// - two cascaded averaging stages form bartlett fir
// - decimator averages n+1 samples per update
// - host reads outputs, reads and writes controls
// - outputs hold data, error flags, identity
// - each register has two byte addresses
// - code 001 direct, 101 pulse sync
// - code 010 selects scaled sync
// - sample ready pulses on output load
`timescale 1ns/100ps
`default_nettype none
module isp_chain_top #(
    parameter int unsigned GYRO_HALF_CYC = isp_pkg::GYRO_HALF_CYC,
    parameter int unsigned PROC_CYC      = isp_pkg::PROC_CYC,
    parameter logic [15:0] DEVICE_ID     = 16'h5A3C  // arbitrary value
) (
    // clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    // sensor converters
    input  wire logic                       conv_valid_i,
    input  wire isp_pkg::isp_vec3_t         gyro_raw_i,
    input  wire isp_pkg::isp_vec3_t         accl_raw_i,
    output logic [isp_pkg::AX-1:0]          gyro_conv_clk_o,
    // external sample clock
    input  wire logic                       sync_i,
    // host byte access
    input  wire logic                       wr_i,
    input  wire logic                       rd_i,
    input  wire logic [isp_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [7:0]                 wdata_i,
    output logic [7:0]                      rdata_o,
    // data ready
    output logic                            sample_ready_o
);
    import isp_pkg::*;

    typedef enum logic [1:0] {CAL_IDLE, CAL_GYRO, CAL_ACCL} isp_cal_st_t;

    typedef struct packed {
        logic [GCNT_W-1:0] gconv_cnt;
        logic              gconv_clk;
        logic [PCNT_W-1:0] proc_cnt;
        logic              sync_prev;
        logic [PER_W-1:0]  per_cnt;
        logic [PER_W-1:0]  per;
        logic [ACC_W-1:0]  acc;
        isp_vec3_t         gyro_raw;
        isp_vec3_t         accl_raw;
        isp_cal_st_t       cal_st;
        isp_vec3_t         gyro_c;
        logic              cal_valid;
        isp_vec_t          cal_data;
        isp_word_t         misc;
        isp_word_t         filt;
        isp_word_t         dec;
        isp_word_t         scale;
        logic [7:0]        wstage;
        isp_vec_t          out_regs;
        isp_word_t         data_cnt;
        isp_word_t         diag;
        logic [7:0]        rdata;
        logic              ready;
    } isp_top_st_t;

    isp_top_st_t s_q;
    isp_top_st_t s_d;

    isp_stage_if cal_if ();
    isp_stage_if fir1_if ();
    isp_stage_if fir2_if ();
    isp_stage_if dec_if ();

    logic [FILT_LOG_W-1:0] fir_len;

    // dot product of one coefficient row with a vector, full width
    function automatic logic signed [WIDE_W-1:0] row_dot(
        input logic [2:0][DW-1:0] coef,
        input isp_vec3_t          v
    );
        logic signed [WIDE_W-1:0] s;
        s = '0;
        for (int j = 0; j < AX; j++) begin
            s = s + WIDE_W'($signed(coef[j]) * $signed(v[j]));
        end
        return s;
    endfunction

    // clamp a wide value to a sample, top bit flags saturation
    function automatic logic [DW:0] sat(input logic signed [WIDE_W-1:0] v);
        logic signed [WIDE_W-1:0] hi;
        logic signed [WIDE_W-1:0] lo;
        hi = WIDE_W'($signed({1'b0, {(DW-1){1'b1}}}));
        lo = -hi - WIDE_W'(1);
        if (v > hi) begin
            return {1'b1, hi[DW-1:0]};
        end else if (v < lo) begin
            return {1'b1, lo[DW-1:0]};
        end
        return {1'b0, v[DW-1:0]};
    endfunction

    assign cal_if.valid = s_q.cal_valid;
    assign cal_if.data  = s_q.cal_data;
    assign fir_len = (s_q.filt[FILT_LOG_W:0] > {1'b0, FILT_LOG_MAX})
                     ? FILT_LOG_MAX : s_q.filt[FILT_LOG_W-1:0];

    isp_avg_stage u_fir1 (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .len_log_i (fir_len),
        .in_if     (cal_if),
        .out_if    (fir1_if)
    );
    isp_avg_stage u_fir2 (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .len_log_i (fir_len),
        .in_if     (fir1_if),
        .out_if    (fir2_if)
    );

    isp_decim u_dec (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .dec_n_i (s_q.dec[DEC_W-1:0]),
        .in_if   (fir2_if),
        .out_if  (dec_if)
    );

    assign gyro_conv_clk_o = {AX{s_q.gconv_clk}};
    assign rdata_o         = s_q.rdata;
    assign sample_ready_o  = s_q.ready;

    // next state of the whole block
    always_comb begin
        logic                  tick;
        logic                  sync_rise;
        logic                  load;
        logic                  sat_hit;
        logic [ACC_W-1:0]      acc_n;
        logic signed [WIDE_W-1:0] w;
        logic [DW:0]           r;
        logic [WIDE_W-1:0]     sq;
        logic [MISC_CLK_W-1:0] mode;
        logic [ADDR_W-1:0]     wa;
        isp_word_t             rw;
        int                    k;
        tick = 1'b0;
        load = 1'b0;
        sat_hit = 1'b0;
        acc_n = '0;
        w = '0;
        r = '0;
        sq = '0;
        k = 0;
        rw = '0;
        s_d = s_q;
        s_d.cal_valid = 1'b0;
        mode = s_q.misc[MISC_CLK_LSB +: MISC_CLK_W];
        sync_rise = sync_i & ~s_q.sync_prev;
        s_d.sync_prev = sync_i;
        wa = {addr_i[ADDR_W-1:1], 1'b0};

        if (s_q.gconv_cnt >= GCNT_W'(GYRO_HALF_CYC - 1)) begin
            s_d.gconv_cnt = '0;
            s_d.gconv_clk = ~s_q.gconv_clk;
        end else begin
            s_d.gconv_cnt = s_q.gconv_cnt + GCNT_W'(1);
        end

        // sync period measurement for scaled mode
        if (sync_rise) begin
            s_d.per     = s_q.per_cnt + PER_W'(1);
            s_d.per_cnt = '0;
        end else if (s_q.per_cnt != {PER_W{1'b1}}) begin
            s_d.per_cnt = s_q.per_cnt + PER_W'(1);
        end

        if (s_q.proc_cnt >= PCNT_W'(PROC_CYC - 1)) begin
            s_d.proc_cnt = '0;
        end else begin
            s_d.proc_cnt = s_q.proc_cnt + PCNT_W'(1);
        end

        case (mode)
            CLK_DIRECT, CLK_PULSE: begin
                tick = sync_rise;
            end
            CLK_SCALED: begin
                acc_n = s_q.acc + ACC_W'(s_q.scale);
                if (s_q.per != '0 && acc_n >= ACC_W'(s_q.per)) begin
                    tick  = 1'b1;
                    acc_n = acc_n - ACC_W'(s_q.per);
                end
                s_d.acc = acc_n;
            end
            default: begin
                tick = (s_q.proc_cnt >= PCNT_W'(PROC_CYC - 1));
            end
        endcase

        // latest converter samples
        if (conv_valid_i) begin
            s_d.gyro_raw = gyro_raw_i;
            s_d.accl_raw = accl_raw_i;
        end

        case (s_q.cal_st)
            CAL_IDLE: begin
                if (tick) begin
                    s_d.cal_st = CAL_GYRO;
                end
            end
            CAL_GYRO: begin
                for (int i = 0; i < AX; i++) begin
                    w = row_dot(GYRO_M[AX*i +: AX], s_q.gyro_raw);
                    if (s_q.misc[MISC_LING_BIT]) begin
                        w = w + row_dot(GYRO_L[AX*i +: AX], s_q.accl_raw);
                    end
                    w = (w >>> FRAC) + WIDE_W'($signed(GYRO_B[i]));
                    r = sat(w);
                    sat_hit = sat_hit | r[DW];
                    s_d.gyro_c[i] = r[DW-1:0];
                end
                s_d.cal_st = CAL_ACCL;
            end
            CAL_ACCL: begin
                for (int i = 0; i < AX; i++) begin
                    w = row_dot(ACCL_M[AX*i +: AX], s_q.accl_raw);
                    for (int j = 0; j < AX; j++) begin
                        k = 2 * i + ((j > i) ? j - 1 : j);
                        sq = WIDE_W'($signed(s_q.gyro_c[j]) * $signed(s_q.gyro_c[j]));
                        if (s_q.misc[MISC_POP_BIT] && j != i) begin
                            w = w + WIDE_W'($signed(ACCL_P[k]) * ($signed(sq) >>> DW));
                        end
                    end
                    w = (w >>> FRAC) + WIDE_W'($signed(ACCL_B[i]));
                    r = sat(w);
                    sat_hit = sat_hit | r[DW];
                    s_d.cal_data[AX+i] = r[DW-1:0];
                    s_d.cal_data[i]    = s_q.gyro_c[i];
                end
                s_d.cal_valid = 1'b1;
                s_d.cal_st    = CAL_IDLE;
            end
            default: begin
                s_d.cal_st = CAL_IDLE;
            end
        endcase

        if (dec_if.valid) begin
            s_d.out_regs = dec_if.data;
            s_d.data_cnt = s_q.data_cnt + DW'(1);
            load = 1'b1;
        end
        s_d.ready = s_q.misc[MISC_DRPOL_BIT] ? load : ~load;

        // sticky error flag, set wins over read clear
        if (rd_i && addr_i == A_DIAG) begin
            s_d.diag[DIAG_SAT_BIT] = 1'b0;
        end
        if (sat_hit) begin
            s_d.diag[DIAG_SAT_BIT] = 1'b1;
        end

        // host writes reach control registers only
        if (wr_i) begin
            // low byte staged until high byte
            if (!addr_i[0]) begin
                s_d.wstage = wdata_i;
            end else if (wa == A_MISC) begin
                s_d.misc = {wdata_i, s_q.wstage};
            end else if (wa == A_FILT) begin
                s_d.filt = {wdata_i, s_q.wstage};
            end else if (wa == A_DEC) begin
                s_d.dec = {wdata_i, s_q.wstage};
            end else if (wa == A_SCALE) begin
                s_d.scale = {wdata_i, s_q.wstage};
            end
        end

        if (rd_i) begin
            if (wa == A_DIAG) begin
                rw = s_q.diag;
            end else if (wa >= A_OUT0 && wa < A_OUT0 + ADDR_W'(2 * CH)) begin
                rw = s_q.out_regs[(wa - A_OUT0) >> 1];
            end else if (wa == A_CNT) begin
                rw = s_q.data_cnt;
            end else if (wa == A_ID) begin
                rw = DEVICE_ID;
            end else if (wa == A_MISC) begin
                rw = s_q.misc;
            end else if (wa == A_FILT) begin
                rw = s_q.filt;
            end else if (wa == A_DEC) begin
                rw = s_q.dec;
            end else if (wa == A_SCALE) begin
                rw = s_q.scale;
            end
            s_d.rdata = addr_i[0] ? rw[DW-1:8] : rw[7:0];
        end
    end

    // tables are constants, no register path
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q       <= '0;
            s_q.misc  <= MISC_DEF;
            s_q.filt  <= FILT_DEF;
            s_q.dec   <= DEC_DEF;
            s_q.scale <= SCALE_DEF;
        end else begin
            s_q <= s_d;
        end
    end
endmodule
`default_nettype wire

// ==== dv/isp_chain_asserts.sv ====
/* port checker for the inertial sample chain top.
   assumes one clock, async reset, ready polarity left at default. */
`timescale 1ns/100ps
`default_nettype none
module isp_chain_asserts
    import isp_pkg::*;
#(
    parameter int unsigned GYRO_HALF_CYC = 5,
    parameter logic [15:0] DEVICE_ID     = 16'h0000
) (
    // clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    // converter clocks
    input  wire logic [isp_pkg::AX-1:0]     gyro_conv_clk_o,
    // host byte access
    input  wire logic                       wr_i,
    input  wire logic                       rd_i,
    input  wire logic [isp_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [7:0]                 wdata_i,
    input  wire logic [7:0]                 rdata_o,
    // data ready
    input  wire logic                       sample_ready_o
);
    logic [2:0]  gclk_q;
    logic [15:0] gcnt_q;
    logic        seen_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // cycles since the converter clock last moved
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            gclk_q <= '0;
            gcnt_q <= '0;
            seen_q <= 1'b0;
        end else begin
            gclk_q <= gyro_conv_clk_o;
            gcnt_q <= (gyro_conv_clk_o != gclk_q) ? 16'h0000 : gcnt_q + 16'h0001;
            seen_q <= seen_q | (gyro_conv_clk_o != gclk_q);
        end
    end

    property p_gclk_half;
        seen_q && gyro_conv_clk_o != gclk_q |-> gcnt_q == GYRO_HALF_CYC - 1;
    endproperty
    a_gclk_half: assert property (p_gclk_half) else $error("converter half period wrong");
    property p_gclk_same; gyro_conv_clk_o == 3'h0 || gyro_conv_clk_o == 3'h7; endproperty
    a_gclk_same: assert property (p_gclk_same) else $error("converter clocks differ");
    property p_ready_one; $rose(sample_ready_o) |=> !sample_ready_o; endproperty
    a_ready_one: assert property (p_ready_one) else $error("ready wider than a cycle");
    property p_reset_quiet; $fell(rst_i) |-> (!sample_ready_o) [*7]; endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("ready too soon");
    property p_rdata_hold; !rd_i |=> $stable(rdata_o); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read byte moved");
    property p_id_lo; rd_i && addr_i == A_ID |=> rdata_o == DEVICE_ID[7:0]; endproperty
    a_id_lo: assert property (p_id_lo) else $error("id low byte wrong");
    property p_id_hi; rd_i && addr_i == A_ID + 7'h01 |=> rdata_o == DEVICE_ID[15:8]; endproperty
    a_id_hi: assert property (p_id_hi) else $error("id high byte wrong");
    property p_unmapped; rd_i && addr_i > 7'h65 |=> rdata_o == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_misc_back;
        wr_i && addr_i == A_MISC ##1 wr_i && addr_i == A_MISC + 7'h01
            ##1 rd_i && addr_i == A_MISC |=> rdata_o == $past(wdata_i, 3);
    endproperty
    a_misc_back: assert property (p_misc_back) else $error("misc low byte lost");
endmodule
`default_nettype wire

// ==== dv/isp_conv_model.sv ====
/* model of the six sensor converters.
   assumes the bench clock; data moves on the falling edge. */
`timescale 1ns/100ps
`default_nettype none
module isp_conv_model (
    // clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // converter clock and level to sample
    input  wire logic [isp_pkg::AX-1:0] conv_clk_i,
    input  wire logic [15:0]            base_i,
    // converter outputs
    output logic                        conv_valid_o,
    output isp_pkg::isp_vec3_t          gyro_o,
    output isp_pkg::isp_vec3_t          accl_o
);
    import isp_pkg::*;
    logic clk_q;
    initial begin
        clk_q = 1'b0;
        conv_valid_o = 1'b0;
        gyro_o = '0;
        accl_o = '0;
    end
    // convert on each converter clock rise, garbage between
    always @(negedge clk_i) begin
        clk_q <= conv_clk_i[0];
        conv_valid_o <= !rst_i && conv_clk_i[0] && !clk_q;
        for (int i = 0; i < AX; i++) begin
            gyro_o[i] <= (conv_clk_i[0] && !clk_q) ? base_i + DW'(i) : ~gyro_o[i];
            accl_o[i] <= (conv_clk_i[0] && !clk_q) ? base_i + 16'h0100 + DW'(i) : ~accl_o[i];
        end
    end
endmodule
`default_nettype wire

// ==== dv/isp_chain_top_tb.sv ====
/* self checking bench of the inertial sample chain top.
   assumes short counts for converter clock and processing tick. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module isp_chain_top_tb;
    import isp_pkg::*;
    localparam int unsigned PC  = 40;
    localparam int unsigned GH  = 5;
    localparam logic [15:0] DID = 16'hA55A; // arbitrary value
    logic        clk_i, rst_i, conv_valid_i, sync_i, wr_i, rd_i, sample_ready_o;
    logic [2:0]  gclk;
    isp_vec3_t   gyro, accl;
    logic [6:0]  addr_i;
    logic [7:0]  wdata_i, rdata_o;
    logic [15:0] base;
    logic [2:0]  modes [2] = '{CLK_DIRECT, CLK_PULSE};
    int          failures, checked, n;

    isp_chain_top #(.GYRO_HALF_CYC(GH), .PROC_CYC(PC), .DEVICE_ID(DID)) isp_chain_top_inst (
        .clk_i(clk_i), .rst_i(rst_i), .conv_valid_i(conv_valid_i), .gyro_raw_i(gyro),
        .accl_raw_i(accl), .gyro_conv_clk_o(gclk), .sync_i(sync_i), .wr_i(wr_i),
        .rd_i(rd_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
        .sample_ready_o(sample_ready_o));
    isp_conv_model isp_conv_model_inst (.clk_i(clk_i), .rst_i(rst_i), .conv_clk_i(gclk),
        .base_i(base), .conv_valid_o(conv_valid_i), .gyro_o(gyro), .accl_o(accl));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    task automatic final_report();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // byte write, strobe left up for a back to back follower
    task automatic wr8(input logic [6:0] a, input logic [7:0] d);
        @(negedge clk_i);
        rd_i = 1'b0;
        wr_i = 1'b1;
        addr_i = a;
        wdata_i = d;
    endtask
    task automatic rd8(input logic [6:0] a, output logic [7:0] d);
        @(negedge clk_i);
        wr_i = 1'b0;
        rd_i = 1'b1;
        addr_i = a;
        @(negedge clk_i);
        rd_i = 1'b0;
        d = rdata_o;
    endtask
    task automatic rchk(input logic [6:0] a, input logic [15:0] e);
        logic [15:0] r;
        rd8(a, r[7:0]);
        rd8(a + 7'h01, r[15:8]);
        `CHK(r, e)
    endtask
    // low byte first, then read back
    task automatic wrchk(input logic [6:0] a, input logic [15:0] v);
        wr8(a, v[7:0]);
        wr8(a + 7'h01, v[15:8]);
        rchk(a, v);
    endtask
    task automatic wait_rdy(input int lim, output int k);
        k = 0;
        do begin
            @(negedge clk_i);
            k++;
        end while (sample_ready_o !== 1'b1 && k < lim);
    endtask

    // watchdog
    initial begin
        #400000;
        failures++;
        final_report();
    end
    initial begin
        logic [15:0] c0;
        failures = 0;
        checked = 0;
        {rst_i, sync_i, wr_i, rd_i, addr_i, wdata_i, base} = {1'b1, 18'h0, 16'h0123};
        repeat (10) @(negedge clk_i);
        rst_i = 1'b0;
        rchk(A_MISC, 16'h00C1);
        rchk(A_FILT, 16'h0000);
        rchk(A_DEC, 16'h0000);
        rchk(A_ID, DID);
        rchk(7'h7E, 16'h0000);
        wait_rdy(200, n);
        wait_rdy(200, n);
        `CHK(n, PC)
        rchk(A_OUT0, base);
        rchk(A_OUT0 + 7'h06, base + 16'h0100);
        rd8(A_CNT, c0[7:0]);
        rd8(A_CNT + 7'h01, c0[15:8]);
        wait_rdy(200, n);
        rchk(A_CNT, c0 + 16'h0001);
        wrchk(A_FILT, 16'h0001);
        wrchk(A_MISC, 16'h0001);
        base = 16'h0456;
        repeat (12) wait_rdy(200, n);
        rchk(A_OUT0, base);
        rchk(A_OUT0 + 7'h06, base + 16'h0100);
        wrchk(A_DEC, 16'h0003);
        repeat (2) wait_rdy(400, n);
        wait_rdy(400, n);
        `CHK(n, 4 * PC)
        wrchk(A_DEC, 16'h0000);
        foreach (modes[i]) begin
            wrchk(A_MISC, {8'h00, 3'h6, modes[i], 2'h1});
            repeat (20) @(negedge clk_i);
            wait_rdy(3 * PC, n);
            `CHK(n, 3 * PC)
            sync_i = 1'b1;
            wait_rdy(12, n);
            `CHK(sample_ready_o, 1'b1)
            sync_i = 1'b0;
        end
        wrchk(A_SCALE, 16'h0002);
        wrchk(A_MISC, {8'h00, 3'h6, CLK_SCALED, 2'h1});
        fork
            repeat (3) begin
                @(negedge clk_i) sync_i = 1'b1;
                @(negedge clk_i) sync_i = 1'b0;
                repeat (118) @(negedge clk_i);
            end
            begin
                repeat (130) @(negedge clk_i);
                repeat (2) wait_rdy(200, n);
                `CHK(n, 60)
            end
        join
        wrchk(A_MISC, 16'h00C1);
        repeat (8) @(negedge clk_i);
        wait_rdy(200, n);
        wait_rdy(200, n);
        `CHK(n, PC)
        final_report();
    end
endmodule
bind isp_chain_top isp_chain_asserts #(.GYRO_HALF_CYC(GYRO_HALF_CYC), .DEVICE_ID(DEVICE_ID))
    isp_chain_asserts_inst (.clk_i(clk_i), .rst_i(rst_i), .gyro_conv_clk_o(gyro_conv_clk_o),
    .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .sample_ready_o(sample_ready_o));
`default_nettype wire
